// ===== rtl/dcsp_core.sv
// Purpose: Position decoding, status events and command gating of a
//          disconnector controller, with a millisecond timebase.
// Assumes: All inputs synchronous to clk_i; feedback already debounced.
// Notes:   Register port answers reads one cycle later, never stalls.
// Notes on behaviour
// [RL1] The two feedback inputs map to intermediate 0, off 1, on 2, bad 3.
// [RL2] Every change of the position code raises one status event.
// [RL3] A command needs the local or remote authority that matches its source.
// [RL4] Open needs the open permit, close needs the close permit.
// [RL5] Authority, permit and no blocking must all hold at once, else refuse.
// [RL6] Operate timing stays within 5 percent or 15 ms of the set value.
// [RL7] Outside logic grants permits only while the breaker is cleanly open.
// [RL8] The filtered opened output is high only while the code is off.
// [RL9] While the operation block input is high every command is refused.
// [RL10] The command pulse ends early on confirmation, never below minimum; a pulse_ms set below MIN_PULSE_MS ends it sooner.
// [RL11] Each operation gives a 150 ms pulse counted by a resettable counter.
// [RL12] A selection not followed by a command in time is dropped unused.
// [RL13] All timing uses a millisecond tick; reset clears timers and counts.
`timescale 1ns/1ps
module dcsp_core
    import dcsp_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic closed_feedback_i,
    input wire logic open_feedback_i,
    input wire logic open_permit_i,
    input wire logic close_permit_i,
    input wire logic operation_block_i,
    input wire logic local_auth_i,
    input wire logic remote_auth_i,
    input wire dcsp_cmd_t cmd_i,
    input wire logic select_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [1:0] position_status_code_o,
    output logic status_event_o,
    output logic opened_o,
    output logic closed_o,
    output logic open_command_pulse_o,
    output logic close_command_pulse_o,
    output logic oper_pulse_o,
    output logic cmd_refused_o,
    output logic irq_o
);
    logic [31:0] ms_div;
    logic ms_tick;
    logic sbo_en;
    logic [15:0] pulse_ms;
    logic [15:0] sbo_ms;
    logic [IRQ_BITS-1:0] irq_stat;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [31:0] op_count;
    logic [15:0] pulse_cnt;
    logic [7:0] oper_cnt;
    logic [15:0] sbo_cnt;
    logic armed;
    logic pulse_busy;
    logic pulse_close;
    dcsp_code_t next_code;
    logic auth_ok;
    logic permit_ok;
    logic accept;
    logic refuse;
    logic confirmed;
    logic pulse_end;
    logic [IRQ_BITS-1:0] irq_set;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    ////////////////////////////////////////////////////////////////////////
    // Millisecond timebase. The tick is exact, so the only timing error is
    // one tick of quantisation, far inside the tolerance band. // RL6
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ms_div <= 32'h0000_0000;
            ms_tick <= 1'b0;
        end else if (ms_div == MS_CYCLES - 1) begin
            ms_div <= 32'h0000_0000; // RL13
            ms_tick <= 1'b1;
        end else begin
            ms_div <= ms_div + 32'h0000_0001;
            ms_tick <= 1'b0;
        end
    end

    property p_tick;
        ms_tick |=> !ms_tick;
    endproperty
    a_tick: assert property (p_tick) // RL13
        else $error("millisecond tick longer than one cycle");

    ////////////////////////////////////////////////////////////////////////
    // Position decoding and status events.
    always_comb begin
        next_code = dcsp_code_t'({closed_feedback_i, open_feedback_i}); // RL1
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            position_status_code_o <= CODE_INTERMEDIATE;
            status_event_o <= 1'b0;
            opened_o <= 1'b0;
            closed_o <= 1'b0;
        end else begin
            position_status_code_o <= next_code;
            status_event_o <= (next_code != position_status_code_o); // RL2
            opened_o <= (next_code == CODE_OFF); // RL8
            closed_o <= (next_code == CODE_ON);
        end
    end

    property p_code;
        resetn_i |=> position_status_code_o ==
            {$past(closed_feedback_i), $past(open_feedback_i)};
    endproperty
    a_code: assert property (p_code) // RL1
        else $error("position code does not follow the feedback pair");

    property p_event;
        resetn_i && $changed(position_status_code_o) |-> status_event_o;
    endproperty
    a_event: assert property (p_event) // RL2
        else $error("position change without a status event");

    property p_opened;
        opened_o == (position_status_code_o == CODE_OFF);
    endproperty
    a_opened: assert property (p_opened) // RL8
        else $error("opened output disagrees with the position code");

    ////////////////////////////////////////////////////////////////////////
    // Command gating. A command arriving while a pulse runs is refused, as
    // a second pulse could drive both coils at once.
    always_comb begin
        auth_ok = cmd_i.remote ? remote_auth_i : local_auth_i; // RL3
        permit_ok = cmd_i.close ? close_permit_i : open_permit_i; // RL4
        accept = cmd_i.valid && auth_ok && permit_ok && !operation_block_i
            && !pulse_busy && (!sbo_en || armed); // RL5 RL9 RL12
        refuse = cmd_i.valid && !accept;
        confirmed = pulse_close ? (position_status_code_o == CODE_ON)
            : (position_status_code_o == CODE_OFF);
        pulse_end = pulse_busy && ms_tick
            && ((pulse_cnt + 16'h0001 >= MIN_PULSE_MS && confirmed)
            || pulse_cnt + 16'h0001 >= pulse_ms); // RL10
    end

    // Select before operate: a selection arms the block for sbo_ms.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            armed <= 1'b0;
            sbo_cnt <= 16'h0000;
        end else if (accept || (armed && ms_tick
            && sbo_cnt + 16'h0001 >= sbo_ms)) begin
            armed <= 1'b0; // RL12
            sbo_cnt <= 16'h0000;
        end else if (select_i && sbo_en) begin
            armed <= 1'b1;
            sbo_cnt <= 16'h0000;
        end else if (armed && ms_tick) begin
            sbo_cnt <= sbo_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pulse_busy <= 1'b0;
            pulse_close <= 1'b0;
            pulse_cnt <= 16'h0000;
            open_command_pulse_o <= 1'b0;
            close_command_pulse_o <= 1'b0;
            cmd_refused_o <= 1'b0;
        end else begin
            cmd_refused_o <= refuse; // RL5
            if (accept) begin
                pulse_busy <= 1'b1;
                pulse_close <= cmd_i.close;
                pulse_cnt <= 16'h0000;
                open_command_pulse_o <= !cmd_i.close;
                close_command_pulse_o <= cmd_i.close;
            end else if (pulse_end) begin
                pulse_busy <= 1'b0; // RL10
                open_command_pulse_o <= 1'b0;
                close_command_pulse_o <= 1'b0;
            end else if (pulse_busy && ms_tick) begin
                pulse_cnt <= pulse_cnt + 16'h0001;
            end
        end
    end

    property p_auth;
        $rose(open_command_pulse_o) |->
            $past(cmd_i.remote ? remote_auth_i : local_auth_i);
    endproperty
    a_auth: assert property (p_auth) // RL3
        else $error("open command issued without matching authority");

    property p_permit;
        $rose(open_command_pulse_o) |-> $past(open_permit_i);
    endproperty
    a_permit: assert property (p_permit) // RL4
        else $error("open command issued without open permit");

    property p_all;
        $rose(close_command_pulse_o) |->
            $past(close_permit_i && !operation_block_i && cmd_i.valid);
    endproperty
    a_all: assert property (p_all) // RL5
        else $error("close command issued with a condition unmet");

    property p_block;
        cmd_i.valid && operation_block_i |=>
            !$rose(open_command_pulse_o) && !$rose(close_command_pulse_o)
            && cmd_refused_o;
    endproperty
    a_block: assert property (p_block) // RL9
        else $error("command not refused while blocked");

    property p_min;
        resetn_i && ($fell(open_command_pulse_o)
            || $fell(close_command_pulse_o)) |->
            $past(pulse_cnt) + 16'h0001 >= MIN_PULSE_MS
            || $past(pulse_cnt) + 16'h0001 >= $past(pulse_ms);
    endproperty
    a_min: assert property (p_min) // RL10
        else $error("command pulse ended below its minimum length");

    property p_sbo;
        cmd_i.valid && sbo_en && !armed |=>
            !$rose(open_command_pulse_o) && !$rose(close_command_pulse_o);
    endproperty
    a_sbo: assert property (p_sbo) // RL12
        else $error("command executed without a live selection");

    property p_one_coil;
        !(open_command_pulse_o && close_command_pulse_o);
    endproperty
    a_one_coil: assert property (p_one_coil) // RL10
        else $error("open and close command pulses high together");

    ////////////////////////////////////////////////////////////////////////
    // Operation pulse and counter; a counter clear loses to an increment.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            oper_pulse_o <= 1'b0;
            oper_cnt <= 8'h00;
        end else if (accept) begin
            oper_pulse_o <= 1'b1; // RL11
            oper_cnt <= 8'h00;
        end else if (oper_pulse_o && ms_tick) begin
            oper_cnt <= oper_cnt + 8'h01;
            if (oper_cnt + 8'h01 >= OPER_MS) begin
                oper_pulse_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            op_count <= 32'h0000_0000; // RL13
        end else if (accept) begin
            op_count <= op_count + 32'h0000_0001; // RL11
        end else if (wr_i && addr_i == ADDR_OP_COUNT) begin
            op_count <= 32'h0000_0000;
        end
    end

    property p_count;
        $rose(oper_pulse_o) |-> op_count == $past(op_count) + 32'h0000_0001;
    endproperty
    a_count: assert property (p_count) // RL11
        else $error("operation counter missed an operation");

    ////////////////////////////////////////////////////////////////////////
    // Register port and interrupt.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sbo_en <= CTRL_SBO_EN_RST;
            pulse_ms <= PULSE_MS_RST;
            sbo_ms <= SBO_MS_RST;
            irq_mask <= IRQ_MASK_RST;
        end else if (wr_i) begin
            case (addr_i)
                ADDR_CTRL: sbo_en <= wdata_i[CTRL_SBO_EN_BIT];
                ADDR_PULSE: pulse_ms <= wdata_i[15:0];
                ADDR_SBO: sbo_ms <= wdata_i[15:0];
                ADDR_IRQ_MASK: irq_mask <= wdata_i[IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_STATUS_BIT] = next_code != position_status_code_o;
        irq_set[IRQ_REFUSED_BIT] = refuse;
        irq_set[IRQ_OPER_BIT] = accept;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_stat <= '0;
            irq_o <= 1'b0;
        end else begin
            if (wr_i && addr_i == ADDR_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~wdata_i[IRQ_BITS-1:0]) | irq_set;
            end else begin
                irq_stat <= irq_stat | irq_set;
            end
            irq_o <= |((irq_stat | irq_set) & irq_mask);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_CTRL: rdata_o <= {31'h0000_0000, sbo_en};
                ADDR_PULSE: rdata_o <= {16'h0000, pulse_ms};
                ADDR_SBO: rdata_o <= {16'h0000, sbo_ms};
                ADDR_STATUS: rdata_o <= {27'h000_0000, armed, pulse_busy,
                    oper_pulse_o, position_status_code_o};
                ADDR_IRQ_STAT: rdata_o <= {29'h0000_0000, irq_stat};
                ADDR_IRQ_MASK: rdata_o <= {29'h0000_0000, irq_mask};
                ADDR_OP_COUNT: rdata_o <= op_count;
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule

// ===== rtl/dcsp_pkg.sv
// Purpose: Shared constants and types of the disconnector status and permit
//          block.
// Assumes: One 25 MHz clock; registers on a plain strobe port.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package dcsp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned MS_NS = 1_000_000;
    localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] MIN_PULSE_MS = 16'h03E8;
    localparam logic [15:0] PULSE_MS_RST = 16'h03E8;
    localparam logic [15:0] SBO_MS_RST = 16'h1388;
    localparam logic [7:0] OPER_MS = 8'h96;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PULSE = 8'h04;
    localparam logic [7:0] ADDR_SBO = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_OP_COUNT = 8'h18;

    localparam int CTRL_SBO_EN_BIT = 0;
    localparam logic CTRL_SBO_EN_RST = 1'b0;
    localparam int IRQ_BITS = 3;
    localparam int IRQ_STATUS_BIT = 0;
    localparam int IRQ_REFUSED_BIT = 1;
    localparam int IRQ_OPER_BIT = 2;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    typedef enum logic [1:0] {
        CODE_INTERMEDIATE,
        CODE_OFF,
        CODE_ON,
        CODE_BAD
    } dcsp_code_t;

    typedef struct packed {
        logic valid;
        logic close;
        logic remote;
    } dcsp_cmd_t;
endpackage

// ===== tb/dcsp_switchgear.sv
// Purpose: Switchgear partner: auxiliary contacts that travel, interlock.
// Assumes: A command pulse stays high while the drive is energised.
// Notes:   Contacts read intermediate while the drive moves.
`timescale 1ns/1ps
module dcsp_switchgear #(
    parameter int TRAVEL = 40
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic open_cmd_i,
    input wire logic close_cmd_i,
    input wire logic breaker_open_i,
    input wire logic jam_i,
    output logic closed_feedback_o,
    output logic open_feedback_o,
    output logic open_permit_o,
    output logic close_permit_o
);
    logic is_closed;
    int moving;
    // Permits are granted only while the breaker is cleanly open.
    assign open_permit_o = breaker_open_i;
    assign close_permit_o = breaker_open_i;
    // A jammed contact set shows both contacts made at once.
    assign closed_feedback_o = jam_i | (moving == 0 && is_closed);
    assign open_feedback_o = jam_i | (moving == 0 && !is_closed);
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            is_closed <= 1'b0;
            moving <= 0;
        end else if (moving > 1) begin
            moving <= moving - 1;
        end else if (moving == 1) begin
            moving <= 0;
            is_closed <= !is_closed;
        end else if (close_cmd_i && !is_closed
            || open_cmd_i && is_closed) begin
            moving <= TRAVEL;
        end
    end
endmodule

// ===== tb/disconnector_status_and_permit_test.sv
// Purpose: Self-checking bench of the disconnector status and permit core.
// Assumes: The millisecond tick is shortened to four clock cycles.
// Notes:   Feedback and permits come from the partner or from table rows.
`timescale 1ns/1ps
module disconnector_status_and_permit_test;
    import dcsp_pkg::*;
    logic clk_i = 0, resetn_i = 0, ovr = 1, ov_c = 0, ov_o = 0;
    logic ov_po = 0, ov_pc = 0, jam = 0, blk = 0, lauth = 0, rauth = 0;
    logic sel = 0, wr = 0, rd = 0, brk = 1;
    dcsp_cmd_t cmd = '0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0, rdata, rv;
    logic [1:0] code;
    logic ev, opened, closed, p_open, p_close, oper, refused, irq;
    logic m_c, m_o, m_po, m_pc;
    int miscompares = 0, comparisons = 0, n, m;
    // Rows {closed, open, code}; each row changes the code.
    logic [3:0] fb_rows [5] = '{4'h5, 4'hA, 4'hF, 4'h0, 4'h5};
    // Rows {remote, lauth, rauth, close, opermit, cpermit, block, accept}.
    logic [7:0] g_rows [8] = '{8'h49, 8'hB5, 8'h2C, 8'hDC, 8'h64, 8'h78,
        8'h6E, 8'hFD};

    dcsp_core #(.MS_CYCLES(4)) i_dcsp_core (.clk_i(clk_i),
        .resetn_i(resetn_i), .closed_feedback_i(ovr ? ov_c : m_c),
        .open_feedback_i(ovr ? ov_o : m_o),
        .open_permit_i(ovr ? ov_po : m_po),
        .close_permit_i(ovr ? ov_pc : m_pc), .operation_block_i(blk),
        .local_auth_i(lauth), .remote_auth_i(rauth), .cmd_i(cmd),
        .select_i(sel), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .position_status_code_o(code),
        .status_event_o(ev), .opened_o(opened), .closed_o(closed),
        .open_command_pulse_o(p_open), .close_command_pulse_o(p_close),
        .oper_pulse_o(oper), .cmd_refused_o(refused), .irq_o(irq));
    dcsp_switchgear i_dcsp_switchgear (.clk_i(clk_i), .resetn_i(resetn_i),
        .open_cmd_i(p_open), .close_cmd_i(p_close), .breaker_open_i(brk),
        .jam_i(jam), .closed_feedback_o(m_c), .open_feedback_o(m_o),
        .open_permit_o(m_po), .close_permit_o(m_pc));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        @(negedge clk_i);
        rv = rdata;
    endtask
    task automatic issue(input logic cl, input logic rem);
        @(posedge clk_i);
        cmd <= '{valid: 1'b1, close: cl, remote: rem};
        @(posedge clk_i);
        cmd <= '0;
        @(negedge clk_i);
    endtask
    task automatic pick;
        @(posedge clk_i);
        sel <= 1'b1;
        @(posedge clk_i);
        sel <= 1'b0;
    endtask
    task automatic stop_test;
        if (miscompares == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // The run needs about 8400 cycles; three and a half times that means a hang.
    initial begin
        #1_200_000;
        miscompares++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        rreg(ADDR_PULSE);
        chk(rv, 32'(PULSE_MS_RST));
        rreg(ADDR_SBO);
        chk(rv, 32'(SBO_MS_RST));
        rreg(ADDR_IRQ_MASK);
        chk(rv, 32'h0000_0000);
        rreg(8'h40);
        chk(rv, 32'h0000_0000);
        wreg(ADDR_IRQ_MASK, 32'h0000_0001);
        foreach (fb_rows[i]) begin
            @(posedge clk_i);
            {ov_c, ov_o} <= fb_rows[i][3:2];
            @(posedge clk_i);
            @(negedge clk_i);
            chk(code, fb_rows[i][1:0]);
            chk(ev, 1);
            chk(opened, fb_rows[i][1:0] == 2'h1);
            chk(closed, fb_rows[i][1:0] == 2'h2);
            @(negedge clk_i);
            chk(ev, 0);
        end
        chk(irq, 1);
        wreg(ADDR_IRQ_STAT, 32'h0000_0001);
        rreg(ADDR_IRQ_STAT);
        chk(rv, 32'h0000_0000);
        wreg(ADDR_IRQ_MASK, 32'h0000_0000);
        wreg(ADDR_PULSE, 32'h0000_0002);
        foreach (g_rows[i]) begin
            @(posedge clk_i);
            {lauth, rauth, ov_po, ov_pc, blk} <=
                {g_rows[i][6:5], g_rows[i][3:1]};
            issue(g_rows[i][4], g_rows[i][7]);
            chk(p_close, g_rows[i][0] & g_rows[i][4]);
            chk(p_open, g_rows[i][0] & !g_rows[i][4]);
            chk(refused, !g_rows[i][0]);
            repeat (20) @(negedge clk_i);
            chk(p_open | p_close, 0);
        end
        chk(irq, 0);
        rreg(ADDR_IRQ_STAT);
        chk(rv, 32'h0000_0006);
        rreg(ADDR_STATUS);
        chk(rv, 32'h0000_0005);
        rreg(ADDR_OP_COUNT);
        chk(rv, 32'h0000_0003);
        wreg(ADDR_OP_COUNT, 32'h0000_0000);
        rreg(ADDR_OP_COUNT);
        chk(rv, 32'h0000_0000);
        // The partner now moves the contacts; the pulse outlives them.
        @(posedge clk_i);
        ovr <= 1'b0;
        wreg(ADDR_PULSE, 32'h0000_07D0);
        issue(1'b1, 1'b0);
        chk(p_close & oper, 1);
        issue(1'b0, 1'b0);
        chk(refused, 1);
        n = 3;
        m = 3;
        while (p_close === 1'b1 && n < 9000) begin
            @(negedge clk_i);
            n++;
            if (oper === 1'b1) m++;
        end
        chk(n >= 3800 && n <= 4200, 1);
        chk(m >= 570 && m <= 630, 1);
        chk(code, 2'h2);
        // A breaker that is not cleanly open withdraws both permits.
        @(posedge clk_i);
        brk <= 1'b0;
        issue(1'b0, 1'b0);
        chk(refused, 1);
        chk(p_open, 0);
        @(posedge clk_i);
        brk <= 1'b1;
        wreg(ADDR_SBO, 32'h0000_0003);
        wreg(ADDR_CTRL, 32'h0000_0001);
        issue(1'b0, 1'b0);
        chk(refused, 1);
        pick();
        issue(1'b0, 1'b0);
        chk(p_open, 1);
        repeat (4100) @(posedge clk_i);
        pick();
        repeat (20) @(posedge clk_i);
        issue(1'b1, 1'b0);
        chk(refused, 1);
        chk(p_close, 0);
        wreg(ADDR_CTRL, 32'h0000_0000);
        issue(1'b1, 1'b0);
        chk(p_close, 1);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        @(negedge clk_i);
        chk(p_close | oper, 0);
        @(posedge clk_i);
        resetn_i <= 1'b1;
        rreg(ADDR_OP_COUNT);
        chk(rv, 32'h0000_0000);
        stop_test();
    end
endmodule
